// *** core/pfsup_pkg.sv ***
package pfsup_pkg;

	// Clock rate and reset extension after recovery
	localparam int unsigned CLK_HZ           = 200_000_000;
	localparam int unsigned RESET_HOLD_MS    = 100;
	localparam int unsigned RESET_HOLD_CYCLES = (CLK_HZ / 1000) * RESET_HOLD_MS;

	// Synchroniser depth for comparator flags
	localparam int unsigned SYNC_STAGES      = 2;

	// Strap encodings
	localparam logic        ROUTE_MAIN       = 1'b0;
	localparam logic        ROUTE_BATTERY    = 1'b1;

	// Supply select output encodings
	localparam logic        SUPPLY_MAIN      = 1'b0;
	localparam logic        SUPPLY_BATTERY   = 1'b1;

	// Reset values
	localparam logic        SYNC_RESET_VALUE = 1'b1;
	localparam logic        NMI_RESET_VALUE  = 1'b0;

	typedef enum logic [2:0]
	{
		PFSUP_RUN     = 3'b001,
		PFSUP_LOW     = 3'b010,
		PFSUP_EXTEND  = 3'b100
	} pfsup_state_t;

endpackage

// *** core/pfsup_supervisor.sv ***
module pfsup_supervisor
#(
	parameter int unsigned HOLD_CYCLES = pfsup_pkg::RESET_HOLD_CYCLES
)
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic rail_below_nmi,
	input  wire logic rail_below_reset,
	input  wire logic nmi_enable_strap,
	input  wire logic battery_route_strap,
	input  wire logic first_bytewide_socket_cs_n_in,
	output logic      nmi_request,
	output logic      hw_reset,
	output logic      first_bytewide_socket_cs_n,
	output logic      first_bytewide_socket_supply_sel
);

	localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);

	logic [pfsup_pkg::SYNC_STAGES-1:0] sync_nmi;
	logic [pfsup_pkg::SYNC_STAGES-1:0] sync_rst;
	logic [pfsup_pkg::SYNC_STAGES-1:0] next_sync_nmi;
	logic [pfsup_pkg::SYNC_STAGES-1:0] next_sync_rst;
	logic                              low_nmi;
	logic                              low_rst;

	pfsup_pkg::pfsup_state_t           state;
	pfsup_pkg::pfsup_state_t           next_state;
	logic [CNT_W-1:0]                  hold_cnt;
	logic [CNT_W-1:0]                  next_hold_cnt;

	logic                              next_nmi_request;
	logic                              next_hw_reset;
	logic                              next_cs_n;
	logic                              next_supply_sel;

	// Comparator synchronisers; only the last stage is used
	always_comb
	begin
		next_sync_nmi = {sync_nmi[pfsup_pkg::SYNC_STAGES-2:0], rail_below_nmi};
		next_sync_rst = {sync_rst[pfsup_pkg::SYNC_STAGES-2:0], rail_below_reset};
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sync_nmi <= {pfsup_pkg::SYNC_STAGES{pfsup_pkg::SYNC_RESET_VALUE}};
			sync_rst <= {pfsup_pkg::SYNC_STAGES{pfsup_pkg::SYNC_RESET_VALUE}};
		end
		else
		begin
			sync_nmi <= next_sync_nmi;
			sync_rst <= next_sync_rst;
		end
	end

	assign low_nmi = sync_nmi[pfsup_pkg::SYNC_STAGES-1];
	assign low_rst = sync_rst[pfsup_pkg::SYNC_STAGES-1];

	// Reset sequencing: low period, then timed extension
	always_comb
	begin
		next_state    = state;
		next_hold_cnt = hold_cnt;
		case (state)
			pfsup_pkg::PFSUP_RUN:
			begin
				if (low_rst)
					next_state = pfsup_pkg::PFSUP_LOW;
			end
			pfsup_pkg::PFSUP_LOW:
			begin
				if (!low_rst)
				begin
					next_state    = pfsup_pkg::PFSUP_EXTEND;
					next_hold_cnt = CNT_W'(HOLD_CYCLES - 1);
				end
			end
			pfsup_pkg::PFSUP_EXTEND:
			begin
				if (low_rst)
					next_state = pfsup_pkg::PFSUP_LOW;
				else if (hold_cnt == '0)
					next_state = pfsup_pkg::PFSUP_RUN;
				else
					next_hold_cnt = hold_cnt - CNT_W'(1);
			end
			default:
			begin
				next_state = pfsup_pkg::PFSUP_LOW;
			end
		endcase
		next_hw_reset = (next_state != pfsup_pkg::PFSUP_RUN);
	end

	// Interrupt, chip-select gating and supply routing
	always_comb
	begin
		next_nmi_request = low_nmi && nmi_enable_strap;
		next_cs_n        = low_nmi | first_bytewide_socket_cs_n_in;
		if (battery_route_strap == pfsup_pkg::ROUTE_BATTERY && (low_nmi || low_rst))
			next_supply_sel = pfsup_pkg::SUPPLY_BATTERY;
		else
			next_supply_sel = pfsup_pkg::SUPPLY_MAIN;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state                            <= pfsup_pkg::PFSUP_LOW;
			hold_cnt                         <= '0;
			hw_reset                         <= 1'b1;
			nmi_request                      <= pfsup_pkg::NMI_RESET_VALUE;
			first_bytewide_socket_cs_n       <= 1'b1;
			first_bytewide_socket_supply_sel <= pfsup_pkg::SUPPLY_MAIN;
		end
		else
		begin
			state                            <= next_state;
			hold_cnt                         <= next_hold_cnt;
			hw_reset                         <= next_hw_reset;
			nmi_request                      <= next_nmi_request;
			first_bytewide_socket_cs_n       <= next_cs_n;
			first_bytewide_socket_supply_sel <= next_supply_sel;
		end
	end

endmodule

// *** sim/pfsup_rail_model.sv ***
module pfsup_rail_model
(
	input  wire logic signed [31:0] mv,
	output logic    rail_below_nmi,
	output logic    rail_below_reset
);
	timeunit 1ns / 1ps;
	assign rail_below_nmi = mv < 4700;
	assign rail_below_reset = mv < 4500;
endmodule

// *** sim/pfsup_assertions.sv ***
module pfsup_assertions
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic rail_below_nmi,
	input wire logic rail_below_reset,
	input wire logic nmi_enable_strap,
	input wire logic battery_route_strap,
	input wire logic nmi_request,
	input wire logic hw_reset,
	input wire logic first_bytewide_socket_cs_n,
	input wire logic first_bytewide_socket_supply_sel
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_nmi_raise: assert property ($past(rail_below_nmi, 3) && $past(nmi_enable_strap)
		|-> nmi_request) else $error("nmi missing");
	a_nmi_off: assert property (!$past(nmi_enable_strap) |-> !nmi_request)
		else $error("nmi not allowed");
	a_rst_raise: assert property ($past(rail_below_reset, 3) |-> hw_reset)
		else $error("reset missing");
	a_rst_hold: assert property ($past(rail_below_reset, 3) |-> hw_reset [*8])
		else $error("reset short");
	a_cs_gate: assert property ($past(rail_below_nmi, 3) |-> first_bytewide_socket_cs_n)
		else $error("select open");
	a_sel_batt: assert property ($past(rail_below_nmi, 3) && $past(battery_route_strap)
		|-> first_bytewide_socket_supply_sel) else $error("no battery");
	a_sel_main: assert property (!$past(battery_route_strap)
		|-> !first_bytewide_socket_supply_sel) else $error("not main");
	a_sync_delay: assert property ($rose(nmi_request) |-> $past(rail_below_nmi, 3))
		else $error("nmi early");
endmodule

// *** sim/testbench.sv ***
module testbench;
	timeunit 1ns / 1ps;
	logic clk_sys = 0, rst = 1, nmi_enable_strap = 0, battery_route_strap = 0;
	logic first_bytewide_socket_cs_n_in = 1;
	wire logic rail_below_nmi, rail_below_reset, nmi_request, hw_reset;
	wire logic first_bytewide_socket_cs_n, first_bytewide_socket_supply_sel;
	wire logic [3:0] o = {nmi_request, hw_reset, first_bytewide_socket_cs_n,
		first_bytewide_socket_supply_sel};
	logic [31:0] x = 32'h25a5, h = 32'h0;
	int mv = 4000, n_errors = 0, n_tests = 0, cnt = 0, cyc = 0;
	always #2.5 clk_sys = ~clk_sys;
	pfsup_rail_model i_rail (.*);
	pfsup_supervisor #(.HOLD_CYCLES(20)) i_dut (.*);
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic chk(logic [3:0] got, logic [3:0] exp);
		n_tests++;
		n_errors += int'(got !== exp);
		if (got !== exp)
			$display("Error %0t outputs %b expected %b", $time, got, exp);
	endtask
	task automatic print_verdict;
		if (n_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Model: flags seen 3 edges late, straps and select 1 edge late
	always @(negedge clk_sys)
	begin
		h = {h[26:0], first_bytewide_socket_cs_n_in, battery_route_strap, nmi_enable_strap,
			rail_below_reset, rail_below_nmi};
		cnt = h[16] ? 0 : cnt + 1;
		if (!rst)
			chk(o, {h[7]&h[15], cnt<21, h[9]|h[15], h[8]&(h[15]|h[16])});
		cyc++;
		n_errors += int'(cyc > 3000);
		if (cyc > 3000)
			print_verdict;
	end
	initial
	begin
		repeat (10) @(posedge clk_sys);
		rst <= 0;
		repeat (60)
		begin
			x = xs(x);
			{nmi_enable_strap, battery_route_strap} <= x[21:20];
			mv <= 4300 + x % 800;
			repeat (1 + x[27:23]) @(posedge clk_sys) first_bytewide_socket_cs_n_in <= x[cyc % 32];
		end
		repeat (40) @(posedge clk_sys) mv <= 5000;
		print_verdict;
	end
endmodule
bind pfsup_supervisor pfsup_assertions i_chk (.*);
